// ### verilog/mrs_pkg.sv
// Purpose: shared constants and carriers for the rtu slave serial port
// Assumes: one 125 MHz clock, setting codes come from same-clock logic
// Notes:
package mrs_pkg;
  localparam int          CLK_PERIOD_NS = 8;              // clock period
  localparam int          CLK_HZ_DEF    = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int          BAUD_TAB [0:4] = '{1200, 2400, 4800, 9600, 19200};
  localparam int          GAP_HALF_BITS = 77;             // 3.5 chars of 11 bits, in half bits
  localparam int          CNT_W         = 23;             // wide enough for gap at 1200
  localparam logic [2:0]  BAUD_CODE_MAX = 3'h4;
  localparam logic [2:0]  BAUD_CODE_RST = 3'h3;
  localparam logic [1:0]  PAR_NONE      = 2'h0;
  localparam logic [1:0]  PAR_ODD       = 2'h1;
  localparam logic [1:0]  PAR_EVEN      = 2'h2;
  localparam logic [1:0]  PAR_RST       = 2'h0;
  localparam logic        STOP_RST      = 1'b0;
  localparam logic [7:0]  NODE_MIN      = 8'h01;
  localparam logic [7:0]  NODE_MAX      = 8'hF7;
  localparam logic [7:0]  NODE_RST      = 8'h01;
  localparam logic [7:0]  FC_READ_IN    = 8'h04;
  localparam logic [7:0]  EXC_MARK      = 8'h80;
  localparam logic [7:0]  EXC_FUNC      = 8'h01;
  localparam logic [7:0]  EXC_ADDR      = 8'h02;
  localparam logic [7:0]  EXC_VALUE     = 8'h03;
  localparam logic [15:0] REG_SHOWN     = 16'h0000;
  localparam logic [15:0] REG_FAULT     = 16'h0007;
  localparam logic [15:0] REG_POINT     = 16'h0008;
  localparam logic [16:0] REG_SPAN      = 17'h0_0009;     // registers 0..8
  localparam logic [3:0]  REQ_LEN       = 4'h8;
  localparam logic [3:0]  MIN_LEN       = 4'h4;
  localparam logic [4:0]  EXC_LEN       = 5'h05;
  localparam logic [4:0]  DATA_IDX      = 5'h03;
  localparam int          FLT_BROKEN    = 0;
  localparam int          FLT_OVER      = 1;
  localparam int          FLT_UNDER     = 2;
  localparam logic [15:0] CRC_INIT      = 16'hFFFF;
  localparam logic [15:0] CRC_POLY      = 16'hA001;

  // link settings as the key menu leaves them
  typedef struct packed {
    logic [2:0] baud_code;
    logic [1:0] parity_code;
    logic       stop_count_code;
    logic [7:0] node_number;
  } mrs_cfg_t;

  // monitor data served to the master
  typedef struct packed {
    logic [15:0] shown_reading;
    logic        probe_broken_flag;
    logic        over_range_flag;
    logic        under_range_flag;
    logic [1:0]  fraction_digits;
  } mrs_mon_t;

  // one byte folded into a crc16, lsb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// ### verilog/mrs_slave.sv
// Purpose: rtu slave serial port, frames requests and serves input registers
// Assumes: CLK_HZ gives at least 16 clocks per bit at 19200
// Notes: rs485 half duplex, receiver is deaf while the driver is on
`timescale 1ns/1ps
`default_nettype none
module mrs_slave
  import mrs_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEF   // lower to shorten bit times in simulation
) (
  input  wire logic     clk,
  input  wire logic     rstn,
  input  wire logic     rx_pin,        // bus receive data, idle high
  input  wire mrs_cfg_t cfg,           // setting codes
  input  wire mrs_mon_t mon,           // live monitor data
  output logic          tx_pin,        // bus transmit data, idle high
  output logic          tx_oe          // bus driver enable, high while driving
);
  typedef logic [CNT_W-1:0] mrs_cnt_t;

  // per-code bit and gap times in clocks
  localparam mrs_cnt_t BITC [0:4] = '{
    mrs_cnt_t'(CLK_HZ / BAUD_TAB[0]), mrs_cnt_t'(CLK_HZ / BAUD_TAB[1]),
    mrs_cnt_t'(CLK_HZ / BAUD_TAB[2]), mrs_cnt_t'(CLK_HZ / BAUD_TAB[3]),
    mrs_cnt_t'(CLK_HZ / BAUD_TAB[4])};
  localparam mrs_cnt_t GAPC [0:4] = '{
    mrs_cnt_t'((GAP_HALF_BITS * (CLK_HZ / BAUD_TAB[0]) + 1) / 2),
    mrs_cnt_t'((GAP_HALF_BITS * (CLK_HZ / BAUD_TAB[1]) + 1) / 2),
    mrs_cnt_t'((GAP_HALF_BITS * (CLK_HZ / BAUD_TAB[2]) + 1) / 2),
    mrs_cnt_t'((GAP_HALF_BITS * (CLK_HZ / BAUD_TAB[3]) + 1) / 2),
    mrs_cnt_t'((GAP_HALF_BITS * (CLK_HZ / BAUD_TAB[4]) + 1) / 2)};

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100
  } mrs_rx_t;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_LOAD  = 3'b001,
    TX_START = 3'b010,
    TX_DATA  = 3'b011,
    TX_PAR   = 3'b100,
    TX_STOP1 = 3'b101,
    TX_STOP2 = 3'b110
  } mrs_tx_t;

  // word seen by the master at each register number
  function automatic logic [15:0] reg_word(input logic [15:0] n, input mrs_mon_t m);
    logic [15:0] w;
    w = 16'h0000;                                         // holes in the map read zero
    unique case (n)
      REG_SHOWN: w = m.shown_reading;
      REG_FAULT: w = {13'h0000, m.under_range_flag, m.over_range_flag,
                      m.probe_broken_flag};
      REG_POINT: w = {14'h0000, m.fraction_digits};
      default:   w = 16'h0000;
    endcase
    return w;
  endfunction

  logic [2:0]  rx_sync_r;      // pin synchroniser chain
  logic        rx_f_r;         // filtered line level
  logic [2:0]  baud_r;         // accepted baud code
  logic [1:0]  par_r;          // accepted parity code
  logic        stop_r;         // accepted stop code
  logic [7:0]  node_r;         // accepted node number
  mrs_rx_t     rx_st;
  mrs_cnt_t    rx_cnt_r;
  logic [2:0]  rx_bit_r;
  logic [7:0]  rx_sh_r;
  logic        rx_perr_r;      // parity error of current char
  logic        rx_done_r;      // one char finished, pulse
  logic        rx_bad_r;       // that char had parity or framing error
  mrs_cnt_t    gap_cnt_r;      // quiet line time
  logic [3:0]  frm_len_r;      // bytes in frame, saturates
  logic        frm_bad_r;      // any char of frame broken
  logic [15:0] crc_r;          // running crc of frame
  logic [7:0]  buf_r [0:7];    // first eight request bytes
  mrs_tx_t     tx_st;
  mrs_cnt_t    tx_cnt_r;
  logic [2:0]  tx_bit_r;
  logic [7:0]  tx_sh_r;
  logic        tx_par_r;
  logic [4:0]  tx_idx_r;       // byte index in reply
  logic [15:0] tx_crc_r;
  logic [7:0]  lo_hold_r;      // low byte caught with its high byte
  logic        rsp_exc_r;
  logic [7:0]  rsp_code_r;
  logic [7:0]  rsp_fc_r;
  logic [15:0] rsp_start_r;
  logic [7:0]  rsp_nbyte_r;
  logic [4:0]  rsp_len_r;
  logic        tx_r;
  logic        tx_en_r;

  // settings and timing selects
  wire logic     link_idle = (rx_st == RX_IDLE) && (tx_st == TX_IDLE);
  wire mrs_cnt_t bit_cyc   = BITC[baud_r];
  wire mrs_cnt_t gap_cyc   = GAPC[baud_r];
  wire logic     rx_zero   = (rx_cnt_r == '0);
  wire logic     tx_zero   = (tx_cnt_r == '0);

  // request decode at the frame boundary
  wire logic        frm_end  = (frm_len_r != 4'h0) && (gap_cnt_r == gap_cyc);
  wire logic [7:0]  f_addr   = buf_r[0];
  wire logic [7:0]  f_fc     = buf_r[1];
  wire logic [15:0] f_start  = {buf_r[2], buf_r[3]};
  wire logic [15:0] f_cnt    = {buf_r[4], buf_r[5]};
  wire logic        crc_ok   = (crc_r == 16'h0000);
  wire logic        fc_ok    = (f_fc == FC_READ_IN);
  wire logic        cnt_bad  = (f_cnt == 16'h0000) || ({1'b0, f_cnt} > REG_SPAN);
  wire logic        rng_bad  = (({1'b0, f_start} + {1'b0, f_cnt}) > REG_SPAN);
  wire logic        accept   = frm_end && !frm_bad_r && crc_ok
                               && (frm_len_r >= MIN_LEN) && (f_addr == node_r);
  wire logic        reply_go = accept && (!fc_ok || (frm_len_r == REQ_LEN));
  wire logic        exc      = !fc_ok || cnt_bad || rng_bad;
  wire logic [7:0]  exc_code = !fc_ok ? EXC_FUNC : (cnt_bad ? EXC_VALUE : EXC_ADDR);

  // reply byte selection
  wire logic [4:0]  dofs    = tx_idx_r - DATA_IDX;
  wire logic [15:0] reg_no  = rsp_start_r + {12'h000, dofs[4:1]};
  wire logic [15:0] word    = reg_word(reg_no, mon);
  wire logic [7:0]  tx_byte =
    (tx_idx_r == 5'h00) ? node_r :
    (tx_idx_r == 5'h01) ? (rsp_exc_r ? (rsp_fc_r | EXC_MARK) : rsp_fc_r) :
    (tx_idx_r == 5'h02) ? (rsp_exc_r ? rsp_code_r : rsp_nbyte_r) :
    (tx_idx_r == rsp_len_r - 5'h02) ? tx_crc_r[7:0] :
    (tx_idx_r == rsp_len_r - 5'h01) ? tx_crc_r[15:8] :
    (dofs[0] ? lo_hold_r : word[15:8]);
  wire logic        crc_fold = (tx_idx_r < rsp_len_r - 5'h02);

  // three-stage pin sync, level taken once stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_sync_r <= 3'h7;
      rx_f_r    <= 1'b1;
    end else begin
      rx_sync_r <= {rx_sync_r[1:0], rx_pin};
      if (rx_sync_r[1] == rx_sync_r[2]) begin
        rx_f_r <= rx_sync_r[2];
      end
    end
  end

  // settings change only while receiver and transmitter are both idle, so also between chars; illegal codes keep the old value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      baud_r <= BAUD_CODE_RST;
      par_r  <= PAR_RST;
      stop_r <= STOP_RST;
      node_r <= NODE_RST;
    end else if (link_idle) begin
      if (cfg.baud_code <= BAUD_CODE_MAX) baud_r <= cfg.baud_code;
      if (cfg.parity_code != 2'h3) par_r <= cfg.parity_code;
      stop_r <= cfg.stop_count_code;
      if (cfg.node_number >= NODE_MIN && cfg.node_number <= NODE_MAX) begin
        node_r <= cfg.node_number;
      end
    end
  end

  // char receiver, samples mid bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_st     <= RX_IDLE;
      rx_cnt_r  <= '0;
      rx_bit_r  <= 3'h0;
      rx_sh_r   <= 8'h00;
      rx_perr_r <= 1'b0;
      rx_done_r <= 1'b0;
      rx_bad_r  <= 1'b0;
    end else begin
      rx_done_r <= 1'b0;
      if (!rx_zero) rx_cnt_r <= rx_cnt_r - 1'b1;
      unique case (rx_st)
        RX_IDLE: if (!rx_f_r) begin
          rx_st     <= RX_START;
          rx_cnt_r  <= bit_cyc >> 1;
          rx_perr_r <= 1'b0;
        end
        RX_START: if (rx_zero) begin
          // a start that is gone at mid bit was a glitch
          rx_st    <= rx_f_r ? RX_IDLE : RX_DATA;
          rx_cnt_r <= bit_cyc - 1'b1;   // zero is a count too, so reload one short
          rx_bit_r <= 3'h0;
        end
        RX_DATA: if (rx_zero) begin
          rx_sh_r  <= {rx_f_r, rx_sh_r[7:1]};
          rx_bit_r <= rx_bit_r + 1'b1;
          rx_cnt_r <= bit_cyc - 1'b1;   // a full bit would drift late each bit
          if (rx_bit_r == 3'h7) rx_st <= (par_r == PAR_NONE) ? RX_STOP : RX_PAR;
        end
        RX_PAR: if (rx_zero) begin
          rx_perr_r <= (^rx_sh_r) ^ rx_f_r ^ (par_r == PAR_ODD);
          rx_cnt_r  <= bit_cyc - 1'b1;
          rx_st     <= RX_STOP;
        end
        RX_STOP: if (rx_zero) begin
          rx_done_r <= 1'b1;
          rx_bad_r  <= rx_perr_r || !rx_f_r;
          rx_st     <= RX_IDLE;
        end
      endcase
    end
  end

  // frame collector, quiet-line timer and crc check
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap_cnt_r <= '0;
      frm_len_r <= 4'h0;
      frm_bad_r <= 1'b0;
      crc_r     <= CRC_INIT;
      for (int i = 0; i < 8; i++) buf_r[i] <= 8'h00;
    end else begin
      if (rx_st != RX_IDLE || !rx_f_r) gap_cnt_r <= '0;
      else if (gap_cnt_r != gap_cyc) gap_cnt_r <= gap_cnt_r + 1'b1;
      if (frm_end) begin
        frm_len_r <= 4'h0;
        frm_bad_r <= 1'b0;
      end else if (rx_done_r && tx_st == TX_IDLE) begin
        // own echo while driving is not a request
        if (frm_len_r != 4'hF) frm_len_r <= frm_len_r + 1'b1;
        if (frm_len_r < REQ_LEN) buf_r[frm_len_r[2:0]] <= rx_sh_r;
        frm_bad_r <= frm_bad_r || rx_bad_r;
        crc_r <= crc_byte((frm_len_r == 4'h0) ? CRC_INIT : crc_r, rx_sh_r);
      end
    end
  end

  // reply transmitter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_st       <= TX_IDLE;
      tx_cnt_r    <= '0;
      tx_bit_r    <= 3'h0;
      tx_sh_r     <= 8'h00;
      tx_par_r    <= 1'b0;
      tx_idx_r    <= 5'h00;
      tx_crc_r    <= CRC_INIT;
      lo_hold_r   <= 8'h00;
      rsp_exc_r   <= 1'b0;
      rsp_code_r  <= 8'h00;
      rsp_fc_r    <= 8'h00;
      rsp_start_r <= 16'h0000;
      rsp_nbyte_r <= 8'h00;
      rsp_len_r   <= EXC_LEN;
      tx_r        <= 1'b1;
      tx_en_r     <= 1'b0;
    end else begin
      if (!tx_zero) tx_cnt_r <= tx_cnt_r - 1'b1;
      unique case (tx_st)
        TX_IDLE: if (reply_go) begin
          rsp_exc_r   <= exc;
          rsp_code_r  <= exc_code;
          rsp_fc_r    <= f_fc;
          rsp_start_r <= f_start;
          rsp_nbyte_r <= {f_cnt[6:0], 1'b0};
          rsp_len_r   <= exc ? EXC_LEN : (EXC_LEN + {f_cnt[3:0], 1'b0});
          tx_idx_r    <= 5'h00;
          tx_st       <= TX_LOAD;
        end
        TX_LOAD: begin
          tx_sh_r  <= tx_byte;
          tx_par_r <= (^tx_byte) ^ (par_r == PAR_ODD);
          // low byte held so a word never tears between its two bytes
          if (!dofs[0]) lo_hold_r <= word[7:0];
          if (crc_fold) tx_crc_r <= crc_byte((tx_idx_r == 5'h00) ? CRC_INIT : tx_crc_r, tx_byte);
          tx_r     <= 1'b0;
          tx_en_r  <= 1'b1;
          tx_cnt_r <= bit_cyc - 1'b1;
          tx_st    <= TX_START;
        end
        TX_START: if (tx_zero) begin
          tx_r     <= tx_sh_r[0];
          tx_sh_r  <= tx_sh_r >> 1;
          tx_bit_r <= 3'h0;
          tx_cnt_r <= bit_cyc - 1'b1;
          tx_st    <= TX_DATA;
        end
        TX_DATA: if (tx_zero) begin
          tx_cnt_r <= bit_cyc - 1'b1;
          if (tx_bit_r == 3'h7) begin
            tx_r  <= (par_r == PAR_NONE) ? 1'b1 : tx_par_r;
            tx_st <= (par_r == PAR_NONE) ? TX_STOP1 : TX_PAR;
          end else begin
            tx_r     <= tx_sh_r[0];
            tx_sh_r  <= tx_sh_r >> 1;
            tx_bit_r <= tx_bit_r + 1'b1;
          end
        end
        TX_PAR: if (tx_zero) begin
          tx_r     <= 1'b1;
          tx_cnt_r <= bit_cyc - 1'b1;
          tx_st    <= TX_STOP1;
        end
        TX_STOP1, TX_STOP2: if (tx_zero) begin
          tx_cnt_r <= bit_cyc - 1'b1;
          if (tx_st == TX_STOP1 && stop_r) tx_st <= TX_STOP2;
          else if (tx_idx_r == rsp_len_r - 5'h01) begin
            tx_en_r <= 1'b0;
            tx_st   <= TX_IDLE;
          end else begin
            tx_idx_r <= tx_idx_r + 1'b1;
            tx_st    <= TX_LOAD;
          end
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  assign tx_pin = tx_r;
  assign tx_oe  = tx_en_r;

  chk_baud_legal: assert property (@(posedge clk) disable iff (!rstn)
    baud_r <= BAUD_CODE_MAX) else $error("baud code out of range");
  chk_par_legal: assert property (@(posedge clk) disable iff (!rstn)
    par_r != 2'h3) else $error("parity code illegal");
  chk_node_legal: assert property (@(posedge clk) disable iff (!rstn)
    node_r >= NODE_MIN && node_r <= NODE_MAX) else $error("node number illegal");
  chk_idle_mark: assert property (@(posedge clk) disable iff (!rstn)
    !tx_en_r |-> tx_r) else $error("line not marking while idle");
  chk_start_bit: assert property (@(posedge clk) disable iff (!rstn)
    $rose(tx_en_r) |-> !tx_r [*8]) else $error("start bit missing or short");
  chk_two_stops: assert property (@(posedge clk) disable iff (!rstn)
    $rose(tx_st == TX_STOP2) |-> stop_r && tx_r) else $error("second stop unasked");
  chk_crc_drop: assert property (@(posedge clk) disable iff (!rstn)
    (frm_end && !crc_ok && tx_st == TX_IDLE) |=> tx_st == TX_IDLE) else $error("bad crc answered");
  chk_fc_only: assert property (@(posedge clk) disable iff (!rstn)
    (tx_st == TX_IDLE && reply_go && !fc_ok) |=> rsp_exc_r) else $error("function not refused");
  chk_reply_addr: assert property (@(posedge clk) disable iff (!rstn)
    $rose(tx_en_r) |-> buf_r[0] == node_r) else $error("reply to foreign node");
endmodule
`default_nettype wire

// ### testbench/mrs_master_model.sv
// Purpose: bus master stand-in, sends requests and collects replies
// Assumes: the line idles high through bus bias, one master only
// Notes: bench sets bitc, par and stops with each change of link settings
`timescale 1ns/1ps
`default_nettype none
module mrs_master_model (
  input  wire logic clk,      // system clock
  output var logic  line_out, // request line into the slave
  input  wire logic tx_pin,   // slave transmit data
  input  wire logic tx_oe     // slave driver enable
);
  int bitc      = 33; // clocks per bit
  int par       = 0;  // 0 none, 1 odd, 2 even
  int stops     = 1;  // stop bits per char
  int frame_err = 0;  // parity, stop or enable faults seen
  int cyc       = 0;  // free cycle stamp
  int t_end     = 0;  // end of last request stop bit
  int t_start   = 0;  // first reply start bit

  initial line_out = 1'b1;
  // stamp for gap timing
  always @(posedge clk) cyc <= cyc + 1;

  // one bit, changed after the edge, held a bit time
  task automatic put_bit(input logic b);
    @(posedge clk);
    line_out <= b;
    repeat (bitc - 1) @(posedge clk);
  endtask

  // chars back to back, lsb first, no flow control
  task automatic send_frame(input logic [7:0] q[$]);
    foreach (q[i]) begin
      put_bit(1'b0);
      for (int k = 0; k < 8; k++) put_bit(q[i][k]);
      if (par != 0) put_bit((^q[i]) ^ (par == 1));
      repeat (stops) put_bit(1'b1);
    end
    t_end = cyc;
  endtask

  // sample mid bit; resync on every start edge
  task automatic get_reply(output logic [7:0] q[$], input int wait_max);
    int n;
    logic [7:0] d;
    q = {};
    n = 0;
    while (!(tx_oe && !tx_pin) && n < wait_max) begin
      @(posedge clk);
      n++;
    end
    t_start = cyc;
    while (tx_oe === 1'b1 && tx_pin === 1'b0) begin
      repeat (bitc / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bitc) @(posedge clk);
        d[i] = tx_pin;
      end
      if (par != 0) begin
        repeat (bitc) @(posedge clk);
        if (tx_pin !== ((^d) ^ (par == 1))) frame_err++;
      end
      repeat (stops) begin
        repeat (bitc) @(posedge clk);
        if (tx_pin !== 1'b1 || tx_oe !== 1'b1) frame_err++;
      end
      q.push_back(d);
      n = 0;
      while (tx_oe && tx_pin && n < 3 * bitc) begin
        @(posedge clk);
        n++;
      end
    end
  endtask
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Purpose: self-checking bench for the rtu slave serial port
// Assumes: CLK_HZ lowered so 19200 still gets 16 clocks a bit
// Notes: 1200 is too slow for the run budget, so it is not exercised
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mrs_pkg::*;
  localparam int SIM_HZ = 320000; // shortened bit times
  localparam int LIMIT  = 100000; // cycle ceiling
  logic       clk        = 1'b0;
  logic       rstn       = 1'b0;
  wire logic  rx_line;
  logic       tx_pin;
  logic       tx_oe;
  mrs_cfg_t   cfg;
  mrs_mon_t   mon;
  int         n_fail     = 0;
  int         n_compared = 0;
  int         cycles     = 0;
  int         seed       = 84;
  int         node       = 1; // node the bench expects
  logic [7:0] body[$];
  logic [7:0] exc_tab [3][3] = '{'{8'h06, 8'h00, 8'h01}, '{8'h04, 8'h00, 8'h00},
                                 '{8'h04, 8'h08, 8'h02}}; // fc, start, count

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  mrs_slave #(.CLK_HZ(SIM_HZ)) dut (.clk(clk), .rstn(rstn), .rx_pin(rx_line), .cfg(cfg),
                                    .mon(mon), .tx_pin(tx_pin), .tx_oe(tx_oe));
  mrs_master_model master (.clk(clk), .line_out(rx_line), .tx_pin(tx_pin), .tx_oe(tx_oe));

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_fail++;
      test_done();
    end
  end

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_int(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_end(input string s);
    $display("test %s finished, failures so far %0d", s, n_fail);
  endtask

  task automatic test_done;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // reflected crc16; a good frame leaves zero
  function automatic int crc16(input logic [7:0] q[$]);
    int c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ q[i];
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction

  function automatic logic [15:0] reg_val(input int a);
    case (a)
      0: return mon.shown_reading;
      7: return {13'h0000, mon.under_range_flag, mon.over_range_flag,
                 mon.probe_broken_flag};
      8: return {14'h0000, mon.fraction_digits};
      default: return 16'h0000;
    endcase
  endfunction

  // expected reply, empty when the slave must stay silent
  task automatic model_reply(input logic [7:0] rq[$], output logic [7:0] ex[$]);
    int st;
    int cn;
    int c;
    logic [15:0] w;
    ex = {};
    if (crc16(rq) != 0 || int'(rq[0]) != node) return;
    st = int'({rq[2], rq[3]});
    cn = int'({rq[4], rq[5]});
    if (rq[1] != 8'h04) ex = {rq[0], rq[1] | 8'h80, 8'h01};
    else if (cn == 0 || cn > 9) ex = {rq[0], 8'h84, 8'h03};
    else if (st + cn > 9) ex = {rq[0], 8'h84, 8'h02};
    else begin
      ex = {rq[0], 8'h04, 8'(2 * cn)};
      for (int r = st; r < st + cn; r++) begin
        w = reg_val(r);
        ex.push_back(w[15:8]);
        ex.push_back(w[7:0]);
      end
    end
    c = crc16(ex);
    ex.push_back(c[7:0]);
    ex.push_back(c[15:8]);
  endtask

  // one request and its reply or silence
  task automatic transact(input logic [7:0] bd[$], input logic [7:0] spoil);
    logic [7:0] rq[$];
    logic [7:0] ex[$];
    logic [7:0] got[$];
    int c;
    int gap;
    rq = bd;
    c = crc16(bd);
    rq.push_back(c[7:0] ^ spoil);
    rq.push_back(c[15:8]);
    master.send_frame(rq);
    // expectation formed after the frame, once monitor inputs have settled
    model_reply(rq, ex);
    gap = (77 * master.bitc + 1) / 2;
    master.get_reply(got, gap + 4 * master.bitc);
    check_int(got.size(), ex.size());
    foreach (ex[i]) begin
      if (i < got.size()) check_byte(got[i], ex[i]);
    end
    c = master.t_start - master.t_end;
    // quiet time runs from the first stop sample, so later stop bits count as gap
    c = int'(c >= gap - master.stops * master.bitc && c <= gap + 2 * master.bitc);
    if (got.size() > 0) check_int(c, 1);
    check_int(master.frame_err, 0);
    master.frame_err = 0;
    repeat (4 * master.bitc) @(posedge clk);
  endtask

  // new setting codes; illegal ones leave the old value
  task automatic set_link(input logic [2:0] b, input logic [1:0] p, input logic s,
                          input logic [7:0] n);
    @(posedge clk);
    cfg <= '{baud_code: b, parity_code: p, stop_count_code: s, node_number: n};
    repeat (8) @(posedge clk);
    if (b <= BAUD_CODE_MAX) master.bitc = SIM_HZ / BAUD_TAB[b];
    if (p != 2'h3) master.par = int'(p);
    master.stops = int'(s) + 1;
    if (n != 8'h00 && n <= NODE_MAX) node = int'(n);
  endtask

  initial begin
    cfg = '{baud_code: 3'h7, parity_code: 2'h3, stop_count_code: 1'b0, node_number: 8'h00};
    mon = '0;
    master.bitc = SIM_HZ / 9600;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    check_byte({6'h00, tx_oe, tx_pin}, 8'h01);
    // defaults hold against illegal codes; sample exchange
    mon.shown_reading <= 16'h0402;
    body = {8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01};
    transact(body, 8'h00);
    @(posedge clk);
    mon.shown_reading <= 16'hFEF6;
    transact(body, 8'h00);
    test_end("defaults");
    // top rate, even parity, random node
    set_link(3'h4, 2'h2, 1'b0, 8'(1 + {$random(seed)} % 247));
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      mon <= '{shown_reading: 16'($random(seed)), probe_broken_flag: k == 1,
               over_range_flag: k == 2, under_range_flag: k == 1 || k == 3,
               fraction_digits: 2'(k)};
      body = {8'(node), 8'h04, 8'h00, 8'h07, 8'h00, 8'h02};
      transact(body, 8'h00);
    end
    mon.shown_reading <= 16'($random(seed));
    body = {8'(node), 8'h04, 8'h00, 8'h00, 8'h00, 8'h09};
    transact(body, 8'h00);
    test_end("map");
    transact(body, 8'h5A);
    body[0] = 8'(node % 247 + 1);
    transact(body, 8'h00);
    body[0] = 8'h00;
    transact(body, 8'h00);
    for (int e = 0; e < 3; e++) begin
      body = {8'(node), exc_tab[e][0], 8'h00, exc_tab[e][1], 8'h00, exc_tab[e][2]};
      transact(body, 8'h00);
    end
    test_end("refusals");
    // slower rates, odd parity, two stops
    for (int b = 2; b >= 1; b--) begin
      set_link(3'(b), 2'h1, 1'b1, 8'(node));
      body = {8'(node), 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
      transact(body, 8'h00);
    end
    test_end("rates");
    test_done();
  end
endmodule
`default_nettype wire
